// File: design/tbp_pkg.sv
package tbp_pkg;
	// register byte offsets
	localparam logic [7:0] REG_DATA = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_STATE = 8'h0C;
	localparam logic [7:0] REG_PKT = 8'h10;
	// status and mask bit positions
	localparam int ST_DONE = 0;
	localparam int ST_ERR = 1;
	localparam logic [1:0] STATUS_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h0;
	// command A fields
	localparam int CA_IOC = 31;
	localparam int CA_ALIGN_HI = 25;
	localparam int CA_ALIGN_LO = 24;
	localparam int CA_OFF_HI = 20;
	localparam int CA_OFF_LO = 16;
	localparam int CA_FIRST = 13;
	localparam int CA_LAST = 12;
	localparam int CA_SIZE_HI = 10;
	localparam int CA_SIZE_LO = 0;
	// command B fields
	localparam int CB_TAG_HI = 31;
	localparam int CB_TAG_LO = 16;
	localparam int CB_LEN_HI = 10;
	localparam int CB_LEN_LO = 0;
	// end alignment codes
	localparam logic [1:0] ALIGN_4B = 2'h0;
	localparam logic [1:0] ALIGN_16B = 2'h1;
	localparam logic [1:0] ALIGN_32B = 2'h2;
	// parser states, one-hot
	typedef enum logic [2:0] {
		S_CMDA = 3'h1,
		S_CMDB = 3'h2,
		S_PAY = 3'h4
	} tbp_state_t;
endpackage : tbp_pkg

// File: design/tbp_lane_mask.sv
`timescale 1ns/1ps
`default_nettype none
// byte lanes of one payload word that fall in [lo, hi)
module tbp_lane_mask (
	// word position and byte window
	input wire logic [10:0] widx,
	input wire logic [11:0] lo,
	input wire logic [11:0] hi,
	// result
	output logic [3:0] be,
	output logic [2:0] nbytes
);
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			logic [12:0] pos;
			assign pos = {widx, 2'(g)};
			assign be[g] = (pos >= {1'b0, lo}) && (pos < {1'b0, hi});
		end
	endgenerate
	assign nbytes = 3'({2'h0, be[0]} + {2'h0, be[1]} + {2'h0, be[2]} + {2'h0, be[3]});
endmodule : tbp_lane_mask
`default_nettype wire

// File: design/tbp_parser.sv
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tbp_parser (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// payload toward the tx fifo
	output logic out_valid,
	output logic [31:0] out_data,
	output logic [3:0] out_be,
	output logic out_last,
	// per-packet status word
	output logic stat_valid,
	output logic [31:0] stat_data,
	// flags and interrupt
	output logic tx_error_flag,
	output logic tx_buffer_done_flag,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////////////
	// bus slave: zero wait states, always okay
	logic dph_wr_q;
	logic [7:0] dph_addr_q;
	logic [31:0] hrdata_q;
	logic addr_phase;
	logic [1:0] status_q;
	logic [1:0] mask_q;
	tbp_pkg::tbp_state_t state_q;
	logic [31:0] pkt_cmdb_q;
	logic [11:0] pkt_bytes_q;
	logic pkt_err_q;
	logic in_pkt_q;

	assign addr_phase = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			dph_wr_q <= 1'b0;
			dph_addr_q <= 8'h00;
		end else begin
			dph_wr_q <= addr_phase && hwrite;
			dph_addr_q <= haddr[7:0];
		end
	end

	// read data is latched in the address phase so it stands from a flop
	always_ff @(posedge core_clk) begin
		if (rst) begin
			hrdata_q <= 32'h0;
		end else if (addr_phase && !hwrite) begin
			unique case (haddr[7:0])
				tbp_pkg::REG_STATUS: hrdata_q <= {30'h0, status_q};
				tbp_pkg::REG_MASK: hrdata_q <= {30'h0, mask_q};
				tbp_pkg::REG_STATE: hrdata_q <= {12'h0, pkt_bytes_q, 4'h0, in_pkt_q, state_q};
				tbp_pkg::REG_PKT: hrdata_q <= {pkt_cmdb_q[tbp_pkg::CB_TAG_HI:tbp_pkg::CB_TAG_LO],
					15'h0, pkt_err_q};
				default: hrdata_q <= 32'h0;
			endcase
		end
	end

	logic word_in;
	logic wr_status;
	logic wr_mask;
	assign word_in = dph_wr_q && (dph_addr_q == tbp_pkg::REG_DATA);
	assign wr_status = dph_wr_q && (dph_addr_q == tbp_pkg::REG_STATUS);
	assign wr_mask = dph_wr_q && (dph_addr_q == tbp_pkg::REG_MASK);

	////////////////////////////////////////////////////////////////////////////////
	// command capture and buffer geometry
	logic [31:0] cmd_a_q;
	logic [10:0] widx_q;
	logic [10:0] total_q;
	logic [11:0] lo_q;
	logic [11:0] hi_q;
	logic [11:0] end_byte;
	logic [11:0] words_used;
	logic [11:0] words_total;
	logic last_word;
	logic cmdb_bad;

	// hi end of the buffer window and the dword count padded to alignment
	assign end_byte = {7'h0, hwdata[tbp_pkg::CA_OFF_HI:tbp_pkg::CA_OFF_LO]}
		+ {1'b0, hwdata[tbp_pkg::CA_SIZE_HI:tbp_pkg::CA_SIZE_LO]};
	assign words_used = (end_byte + 12'h003) >> 2;
	always_comb begin
		unique case (hwdata[tbp_pkg::CA_ALIGN_HI:tbp_pkg::CA_ALIGN_LO])
			tbp_pkg::ALIGN_16B: words_total = (words_used + 12'h003) & 12'hFFC;
			tbp_pkg::ALIGN_32B: words_total = (words_used + 12'h007) & 12'hFF8;
			default: words_total = words_used;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cmd_a_q <= 32'h0;
			total_q <= 11'h0;
			lo_q <= 12'h0;
			hi_q <= 12'h0;
		end else if (word_in && state_q == tbp_pkg::S_CMDA) begin
			cmd_a_q <= hwdata;
			total_q <= words_total[10:0];
			lo_q <= {7'h0, hwdata[tbp_pkg::CA_OFF_HI:tbp_pkg::CA_OFF_LO]};
			hi_q <= end_byte;
		end
	end

	assign last_word = (widx_q == total_q - 11'h001);
	assign cmdb_bad = in_pkt_q && !cmd_a_q[tbp_pkg::CA_FIRST] && (hwdata != pkt_cmdb_q);

	////////////////////////////////////////////////////////////////////////////////
	// position tracking
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= tbp_pkg::S_CMDA;
			widx_q <= 11'h0;
		end else if (word_in) begin
			unique case (state_q)
				tbp_pkg::S_CMDA: state_q <= tbp_pkg::S_CMDB;
				tbp_pkg::S_CMDB: begin
					widx_q <= 11'h0;
					// an empty buffer has no payload words at all
					state_q <= (total_q == 11'h0) ? tbp_pkg::S_CMDA : tbp_pkg::S_PAY;
				end
				tbp_pkg::S_PAY: begin
					widx_q <= widx_q + 11'h001;
					if (last_word) begin
						state_q <= tbp_pkg::S_CMDA;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// payload lanes: only words with live bytes go on to the fifo
	logic [3:0] be;
	logic [2:0] nbytes;
	logic pay_word;
	logic buf_end;
	logic [11:0] pkt_bytes_d;
	logic new_pkt;
	logic [31:0] cur_cmdb;
	logic [11:0] cur_bytes;

	tbp_lane_mask tbp_lane_mask_inst (
		.widx(widx_q),
		.lo(lo_q),
		.hi(hi_q),
		.be(be),
		.nbytes(nbytes)
	);

	assign pay_word = word_in && state_q == tbp_pkg::S_PAY;
	assign buf_end = (pay_word && last_word)
		|| (word_in && state_q == tbp_pkg::S_CMDB && total_q == 11'h0);
	// an empty buffer ends on its own command b, so that word already counts
	assign new_pkt = word_in && state_q == tbp_pkg::S_CMDB
		&& (cmd_a_q[tbp_pkg::CA_FIRST] || !in_pkt_q);
	assign cur_cmdb = new_pkt ? hwdata : pkt_cmdb_q;
	assign cur_bytes = new_pkt ? 12'h0 : pkt_bytes_q;
	assign pkt_bytes_d = cur_bytes + (pay_word ? {9'h0, nbytes} : 12'h0);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_data <= 32'h0;
			out_be <= 4'h0;
			out_last <= 1'b0;
		end else begin
			out_valid <= pay_word && (be != 4'h0);
			if (pay_word) begin
				out_data <= hwdata;
				out_be <= be;
				out_last <= (widx_q == 11'((hi_q - 12'h001) >> 2)) && cmd_a_q[tbp_pkg::CA_LAST];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// packet tracking: command b agreement and byte count
	logic set_err;
	logic len_bad;
	assign len_bad = pkt_bytes_d != {1'b0, cur_cmdb[tbp_pkg::CB_LEN_HI:tbp_pkg::CB_LEN_LO]};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pkt_cmdb_q <= 32'h0;
			in_pkt_q <= 1'b0;
			pkt_bytes_q <= 12'h0;
			pkt_err_q <= 1'b0;
		end else begin
			if (word_in && state_q == tbp_pkg::S_CMDB) begin
				if (cmd_a_q[tbp_pkg::CA_FIRST] || !in_pkt_q) begin
					pkt_cmdb_q <= hwdata;
					pkt_bytes_q <= 12'h0;
					pkt_err_q <= 1'b0;
				end else if (cmdb_bad) begin
					pkt_err_q <= 1'b1;
				end
				in_pkt_q <= 1'b1;
			end else if (pay_word) begin
				pkt_bytes_q <= pkt_bytes_d;
			end
			if (buf_end && cmd_a_q[tbp_pkg::CA_LAST]) begin
				in_pkt_q <= 1'b0;
				if (len_bad) begin
					pkt_err_q <= 1'b1;
				end
			end
		end
	end

	assign set_err = (word_in && state_q == tbp_pkg::S_CMDB && cmdb_bad)
		|| (buf_end && cmd_a_q[tbp_pkg::CA_LAST] && len_bad);

	// status word for the packet; tag lets software pair status to packets
	always_ff @(posedge core_clk) begin
		if (rst) begin
			stat_valid <= 1'b0;
			stat_data <= 32'h0;
		end else begin
			stat_valid <= buf_end && cmd_a_q[tbp_pkg::CA_LAST];
			if (buf_end && cmd_a_q[tbp_pkg::CA_LAST]) begin
				stat_data <= {cur_cmdb[tbp_pkg::CB_TAG_HI:tbp_pkg::CB_TAG_LO], 15'h0,
					(pkt_err_q && !new_pkt) || set_err};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sticky flags, write one to clear; a new event beats the clear
	logic [1:0] set_bits;
	assign set_bits = {set_err, buf_end && cmd_a_q[tbp_pkg::CA_IOC]};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			status_q <= tbp_pkg::STATUS_RST;
		end else begin
			status_q <= (status_q & ~(wr_status ? hwdata[1:0] : 2'h0)) | set_bits;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mask_q <= tbp_pkg::MASK_RST;
		end else if (wr_mask) begin
			mask_q <= hwdata[1:0];
		end
	end

	assign tx_error_flag = status_q[tbp_pkg::ST_ERR];
	assign tx_buffer_done_flag = status_q[tbp_pkg::ST_DONE];
	assign irq = |(status_q & mask_q);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_cmd_order: assert property (@(posedge core_clk) disable iff (rst)
		(word_in && state_q == tbp_pkg::S_CMDA) |=> (state_q == tbp_pkg::S_CMDB))
		else $error("command a not followed by command b state");

	a_cmd_a_held: assert property (@(posedge core_clk) disable iff (rst)
		(word_in && state_q == tbp_pkg::S_CMDA) |=> (cmd_a_q == $past(hwdata)))
		else $error("command a word not captured");

	a_tag_capture: assert property (@(posedge core_clk) disable iff (rst)
		(word_in && state_q == tbp_pkg::S_CMDB && cmd_a_q[tbp_pkg::CA_FIRST])
		|=> (pkt_cmdb_q[31:16] == $past(hwdata[31:16])))
		else $error("packet tag not captured on first buffer");

	a_status_tag: assert property (@(posedge core_clk) disable iff (rst)
		(buf_end && cmd_a_q[tbp_pkg::CA_LAST])
		|=> (stat_valid && stat_data[31:16] == pkt_cmdb_q[31:16]))
		else $error("status word lacks packet tag");

	a_mismatch_err: assert property (@(posedge core_clk) disable iff (rst)
		(word_in && state_q == tbp_pkg::S_CMDB && cmdb_bad) |=> tx_error_flag)
		else $error("command b mismatch did not raise error");

	a_done_flag: assert property (@(posedge core_clk) disable iff (rst)
		(buf_end && cmd_a_q[tbp_pkg::CA_IOC]) |=> tx_buffer_done_flag
		##1 (tx_buffer_done_flag || $past(wr_status && hwdata[tbp_pkg::ST_DONE])))
		else $error("buffer done not raised or not sticky");

	a_irq_gate: assert property (@(posedge core_clk) disable iff (rst)
		(mask_q == 2'h0) |-> !irq)
		else $error("interrupt raised while fully masked");

	a_no_empty_word: assert property (@(posedge core_clk) disable iff (rst)
		out_valid |-> (out_be != 4'h0))
		else $error("word without live bytes passed on");

	a_head_skip: assert property (@(posedge core_clk) disable iff (rst)
		(pay_word && ({widx_q, 2'h3} < {1'b0, lo_q})) |=> !out_valid)
		else $error("bytes before start offset passed on");

	a_len_err: assert property (@(posedge core_clk) disable iff (rst)
		(buf_end && cmd_a_q[tbp_pkg::CA_LAST] && len_bad) |=> (tx_error_flag && stat_data[0]))
		else $error("length mismatch not flagged");

	a_tail_strip: assert property (@(posedge core_clk) disable iff (rst)
		(pay_word && ({widx_q, 2'h0} >= {1'b0, hi_q})) |=> !out_valid)
		else $error("end padding word passed on");

	a_back_to_a: assert property (@(posedge core_clk) disable iff (rst)
		(pay_word && last_word) |=> (state_q == tbp_pkg::S_CMDA))
		else $error("parser did not return to command a");

	a_irq_route: assert property (@(posedge core_clk) disable iff (rst)
		(tx_buffer_done_flag && mask_q[tbp_pkg::ST_DONE]) |-> irq)
		else $error("unmasked done flag not routed to interrupt");

	a_stat_once: assert property (@(posedge core_clk) disable iff (rst)
		stat_valid |=> !stat_valid)
		else $error("status word reported twice in a row");
endmodule : tbp_parser
`default_nettype wire

// File: verification/tbp_host.sv
`timescale 1ns/1ps
`default_nettype none
module tbp_host (
	// clock and answer
	input wire logic core_clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// master drive
	output var logic hsel,
	output var logic [31:0] haddr,
	output var logic [1:0] htrans,
	output var logic hwrite,
	output var logic [2:0] hsize,
	output var logic [31:0] hwdata,
	output var logic hung
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		hung = 1'b0;
	end
	// bounded: a stuck slave flags hung rather than hanging the run
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (hready !== 1'b1) hung <= 1'b1;
	endtask : wait_rdy
	task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask : xfer
	// commands always lead, A before B, both in every buffer
	task automatic send(input logic [31:0] a, b, input int n);
		logic [31:0] q;
		xfer(1'b1, {24'h0, tbp_pkg::REG_DATA}, a, q);
		xfer(1'b1, {24'h0, tbp_pkg::REG_DATA}, b, q);
		for (int i = 0; i < n; i++) begin
			xfer(1'b1, {24'h0, tbp_pkg::REG_DATA}, 32'hC0DE_0000 + i, q);
		end
	endtask : send
endmodule : tbp_host
`default_nettype wire

// File: verification/tx_buffer_command_parser_test.sv
`timescale 1ns/1ps
`default_nettype none
module tx_buffer_command_parser_test;
	logic core_clk, rst, hsel, hwrite, hreadyout, hresp, hung;
	logic out_valid, out_last, stat_valid, tx_error_flag, tx_buffer_done_flag, irq;
	logic [31:0] haddr, hwdata, hrdata, out_data, stat_data, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] out_be;
	logic [36:0] outq[$];
	logic [31:0] statq[$];
	int mismatches = 0;
	int checks = 0;
	tbp_parser tbp_parser_inst (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .out_valid(out_valid),
		.out_data(out_data), .out_be(out_be), .out_last(out_last), .stat_valid(stat_valid),
		.stat_data(stat_data), .tx_error_flag(tx_error_flag),
		.tx_buffer_done_flag(tx_buffer_done_flag), .irq(irq));
	tbp_host tbp_host_inst (.core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hung(hung));
	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// no back-pressure, so every pulse is logged at its edge
	always @(posedge core_clk) begin
		if (out_valid === 1'b1) outq.push_back({out_last, out_be, out_data});
		if (stat_valid === 1'b1) statq.push_back(stat_data);
	end
	task automatic check(input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		if (hung !== 1'b0) mismatches++;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : tally_and_finish
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		tbp_host_inst.xfer(1'b0, {24'h0, a}, 32'h0, d);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		tbp_host_inst.xfer(1'b1, {24'h0, a}, d, x);
		@(posedge core_clk);
	endtask : wr
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(tbp_pkg::REG_STATUS, q);
		check(q, 32'h0);
		rd(tbp_pkg::REG_STATE, q);
		check(q, 32'h1);
		rd(8'h20, q);
		check(q, 32'h0);
		check(hresp, 1'b0);
		wr(tbp_pkg::REG_MASK, 32'h3);
		rd(tbp_pkg::REG_MASK, q);
		check(q, 32'h3);
		wr(tbp_pkg::REG_MASK, 32'h0);
		check(irq, 1'b0);
	endtask : t_reset
	// offset 1, six bytes, completion interrupt requested
	task automatic t_single;
		outq.delete();
		statq.delete();
		tbp_host_inst.send(32'h8001_3006, 32'hA5C3_0006, 2);
		rd(tbp_pkg::REG_STATUS, q);
		check(q, 32'h1);
		check(tx_buffer_done_flag, 1'b1);
		check(outq.size(), 32'h2);
		check(outq[0][35:32], 4'hE);
		check(outq[0][31:8], 24'hC0DE00);
		check(outq[1][36:32], 5'h17);
		check(statq[0], 32'hA5C3_0000);
		rd(tbp_pkg::REG_STATE, q);
		check(q, 32'h0000_0601);
		check(irq, 1'b0);
		wr(tbp_pkg::REG_MASK, 32'h1);
		check(irq, 1'b1);
		wr(tbp_pkg::REG_STATUS, 32'h1);
		check(irq, 1'b0);
		wr(tbp_pkg::REG_MASK, 32'h0);
	endtask : t_single
	// second buffer repeats the packet with a changed command B
	task automatic t_errors;
		statq.delete();
		tbp_host_inst.send(32'h0000_2004, 32'h0001_0008, 1);
		tbp_host_inst.send(32'h0000_1004, 32'h0002_0008, 1);
		rd(tbp_pkg::REG_STATUS, q);
		check(q, 32'h2);
		check(tx_error_flag, 1'b1);
		check(statq[0], 32'h0001_0001);
		wr(tbp_pkg::REG_STATUS, 32'h3);
		statq.delete();
		tbp_host_inst.send(32'h0000_3004, 32'h0003_0005, 1);
		rd(tbp_pkg::REG_STATUS, q);
		check(q, 32'h2);
		check(statq[0], 32'h0003_0001);
		wr(tbp_pkg::REG_STATUS, 32'h3);
	endtask : t_errors
	// empty buffer, then 16- and 32-byte end alignment: padding words must vanish
	task automatic t_align;
		statq.delete();
		tbp_host_inst.send(32'h8000_3000, 32'h0006_0000, 0);
		rd(tbp_pkg::REG_STATUS, q);
		check(q, 32'h1);
		check(statq[0], 32'h0006_0000);
		wr(tbp_pkg::REG_STATUS, 32'h1);
		outq.delete();
		tbp_host_inst.send(32'h0100_3004, 32'h0004_0004, 4);
		rd(tbp_pkg::REG_STATE, q);
		check(q, 32'h0000_0401);
		check(outq.size(), 32'h1);
		rd(tbp_pkg::REG_STATUS, q);
		check(q, 32'h0);
		outq.delete();
		tbp_host_inst.send(32'h0207_3005, 32'h0005_0005, 8);
		rd(tbp_pkg::REG_STATUS, q);
		check(q, 32'h0);
		check(outq.size(), 32'h2);
		check(outq[0][31:0], 32'hC0DE_0001);
		check(outq[0][35:32], 4'h8);
		check(outq[1][36:32], 5'h1F);
	endtask : t_align
	////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_reset();
		t_single();
		t_errors();
		t_align();
		tally_and_finish();
	end
	initial begin
		repeat (5000) @(posedge core_clk);
		mismatches++;
		tally_and_finish();
	end
endmodule : tx_buffer_command_parser_test
`default_nettype wire
